// ===== scg_pkg.sv
/*
 * Package for the system clock generation block: source codes, register
 * offsets, field positions, reset values and timing constants.
 * Assumes a single 10 MHz system clock; oscillators arrive as sampled levels.
 */
package scg_pkg;

   // oscillator source selected by nonvolatile configuration bits
   typedef enum logic [2:0] {
      SCG_SRC_XTAL_LOW,
      SCG_SRC_XTAL_MED,
      SCG_SRC_XTAL_HIGH,
      SCG_SRC_RC,
      SCG_SRC_WDOG,
      SCG_SRC_EXT
   } scg_src_e;

   // crystal range limits and watchdog and rc oscillator rates in kHz
   localparam int SCG_XLOW_MIN_KHZ = 20;
   localparam int SCG_XLOW_MAX_KHZ = 100;
   localparam int SCG_XMED_MAX_KHZ = 4000;
   localparam int SCG_XHIGH_MAX_KHZ = 12000;
   localparam int SCG_WDOG_KHZ = 400;
   localparam int SCG_RC_KHZ = 7373;

   // register offsets on the plain register port
   localparam logic [3:0] SCG_OFS_TRIM = 4'h0;
   localparam logic [3:0] SCG_OFS_DIV = 4'h1;
   localparam logic [3:0] SCG_OFS_AUX1 = 4'h2;
   localparam logic [3:0] SCG_OFS_STAT = 4'h3;

   // trim register fields, aux1 low-power bit and divider width
   localparam int SCG_TRIM_W = 6;
   localparam int SCG_CLKOUT_EN_BIT = 6;
   localparam int SCG_LP_BIT = 7;
   localparam int SCG_DIV_W = 8;

   // factory trim for the nominal rc frequency; value arbitrary
   localparam logic [5:0] SCG_TRIM_RST = 6'h20;
   localparam logic [7:0] SCG_DIV_RST = 8'h00;

   // wake-up hold-off
   localparam int SCG_WAKE_XTAL_CYC = 992;
   localparam int SCG_WAKE_OTHER_CYC = 224;
   localparam int SCG_WAKE_MIN_US = 60;
   localparam int SCG_CLK_MHZ = 10;
   // least time rounds up; an integer MHz rate gives an exact figure
   localparam int SCG_WAKE_FIX_CYC = SCG_WAKE_MIN_US * SCG_CLK_MHZ;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } scg_bus_req_s;

   typedef struct packed {
      logic clk_out_o;
      logic clk_out_oe_n;
   } scg_pin_s;

endpackage

// ===== scg_top.sv
/*
 * System clock generation: source selection, wake-up hold-off, cpu clock
 * divider, peripheral clock, trim register, low-power select, clock out.
 * Assumes clk_sys is fast against every oscillator; oscillator clocks arrive
 * as levels synchronous to clk_sys and derived clocks leave as levels.
 */
// Contract
// - crystal supports low, medium and high ranges, resonators too
// - clock out only when crystal unused by cpu and rtc
// - clock out driven only while its enable bit is set
// - clock out toggles at half the cpu core clock
// - six-bit trim value tunes the rc oscillator
// - reset loads trim with factory value for nominal rc frequency
// - only power-on reset reloads trim; other resets keep it
// - trim is writable by software
// - watchdog oscillator at 400 kHz is a selectable source
// - in external mode crystal output pin is port or clock out
// - crystal source holds cpu clock 992 cycles plus fixed delay
// - other sources hold cpu clock 224 cycles plus fixed delay
// - programmable divider derives cpu clock, ratio up to 510
// - divider may change anytime without glitching the cpu clock; a write of 0 takes effect at once and can cut a cpu clock phase short
// - every reset clears low-power select
// - oscillator clock picked from sources by configuration bits
// - peripheral clock runs at half the cpu clock
`timescale 1ns/1ps
module scg_top
#(
   parameter int DIV_W = scg_pkg::SCG_DIV_W,
   parameter int TRIM_W = scg_pkg::SCG_TRIM_W,
   parameter int XTAL_WAKE = scg_pkg::SCG_WAKE_XTAL_CYC,
   parameter int OTHER_WAKE = scg_pkg::SCG_WAKE_OTHER_CYC,
   parameter int FIX_WAKE = scg_pkg::SCG_WAKE_FIX_CYC
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic por,
   input wire logic ce,
   input wire scg_pkg::scg_src_e src_cfg,
   input wire logic rtc_on_xtal,
   input wire logic xtal_osc,
   input wire logic rc_osc,
   input wire logic wdog_osc,
   input wire logic crystal_input_pin,
   input wire logic port_out,
   input wire logic port_oe_n,
   input wire scg_pkg::scg_bus_req_s bus,
   output logic [7:0] rdata,
   output logic [TRIM_W-1:0] rc_trim,
   output logic low_power_clock_select,
   output logic cpu_core_clock,
   output logic periph_clock,
   output logic cpu_clock_run,
   output scg_pkg::scg_pin_s crystal_output_pin
);

   localparam int WCNT_W = 16;

   logic [TRIM_W-1:0] trim_q;
   logic clk_out_en_q;
   logic lp_q;
   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] div_act_q;
   logic [DIV_W-1:0] div_cnt_q;
   logic [7:0] rdata_q;
   logic osc_q;
   logic cpu_core_clock_q;
   logic pclk_q;
   logic cko_q;
   logic run_q;
   logic [WCNT_W-1:0] wcnt_q;
   logic fix_phase_q;
   logic cpu_core_clock_d_next;

   // source selection
   wire logic xtal_src = (src_cfg == scg_pkg::SCG_SRC_XTAL_LOW) ||
      (src_cfg == scg_pkg::SCG_SRC_XTAL_MED) ||
      (src_cfg == scg_pkg::SCG_SRC_XTAL_HIGH);
   logic osc_sel;
   always_comb
   begin
      unique case (src_cfg)
         scg_pkg::SCG_SRC_XTAL_LOW,
         scg_pkg::SCG_SRC_XTAL_MED,
         scg_pkg::SCG_SRC_XTAL_HIGH: osc_sel = xtal_osc;
         scg_pkg::SCG_SRC_RC: osc_sel = rc_osc;
         scg_pkg::SCG_SRC_WDOG: osc_sel = wdog_osc;
         scg_pkg::SCG_SRC_EXT: osc_sel = crystal_input_pin;
         default: osc_sel = 1'b0;
      endcase
   end
   wire logic osc_rise = osc_sel && !osc_q;

   // register port
   wire logic wr_trim = bus.wr && (bus.addr == scg_pkg::SCG_OFS_TRIM);
   wire logic wr_div = bus.wr && (bus.addr == scg_pkg::SCG_OFS_DIV);
   wire logic wr_aux = bus.wr && (bus.addr == scg_pkg::SCG_OFS_AUX1);
   logic [7:0] rd_mux;
   always_comb
   begin
      rd_mux = 8'h00;
      if (bus.addr == scg_pkg::SCG_OFS_TRIM)
      begin
         rd_mux[TRIM_W-1:0] = trim_q;
         rd_mux[scg_pkg::SCG_CLKOUT_EN_BIT] = clk_out_en_q;
      end
      else if (bus.addr == scg_pkg::SCG_OFS_DIV)
         rd_mux[DIV_W-1:0] = div_q;
      else if (bus.addr == scg_pkg::SCG_OFS_AUX1)
         rd_mux[scg_pkg::SCG_LP_BIT] = lp_q;
      else if (bus.addr == scg_pkg::SCG_OFS_STAT)
         rd_mux[0] = run_q;
   end

   // trim survives ordinary resets, only power-on reloads it
   always_ff @(posedge clk_sys)
   begin
      if (por)
      begin
         trim_q <= scg_pkg::SCG_TRIM_RST;
         clk_out_en_q <= 1'b0;
      end
      // a plain reset blocks writes, so trim stays as it was
      else if (ce && wr_trim && !rst)
      begin
         trim_q <= bus.wdata[TRIM_W-1:0];
         clk_out_en_q <= bus.wdata[scg_pkg::SCG_CLKOUT_EN_BIT];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst || por)
      begin
         lp_q <= 1'b0;
         div_q <= scg_pkg::SCG_DIV_RST;
         rdata_q <= 8'h00;
      end
      else if (ce)
      begin
         if (wr_aux)
            lp_q <= bus.wdata[scg_pkg::SCG_LP_BIT];
         if (wr_div)
            div_q <= bus.wdata[DIV_W-1:0];
         rdata_q <= bus.rd ? rd_mux : 8'h00;
      end
   end

   // wake-up: oscillator edges first, then fixed delay in sys cycles
   wire logic [WCNT_W-1:0] wake_osc = xtal_src ?
      WCNT_W'(XTAL_WAKE) : WCNT_W'(OTHER_WAKE);
   always_ff @(posedge clk_sys)
   begin
      if (rst || por)
      begin
         run_q <= 1'b0;
         wcnt_q <= '0;
         fix_phase_q <= 1'b0;
      end
      else if (ce && !run_q)
      begin
         if (!fix_phase_q)
         begin
            if (osc_rise)
            begin
               if (wcnt_q == wake_osc - 1'b1)
               begin
                  wcnt_q <= '0;
                  fix_phase_q <= 1'b1;
               end
               else
                  wcnt_q <= wcnt_q + 1'b1;
            end
         end
         else if (wcnt_q == WCNT_W'(FIX_WAKE - 1))
            run_q <= 1'b1;
         else
            wcnt_q <= wcnt_q + 1'b1;
      end
   end

   // divider: a nonzero ratio is only taken at a period boundary, so no runt
   // pulse reaches the cpu when software rewrites it; a ratio of 0 takes effect at once
   wire logic div_end = (div_cnt_q == div_act_q - 1'b1) ||
      (div_act_q == '0);
   always_ff @(posedge clk_sys)
   begin
      if (rst || por)
      begin
         osc_q <= 1'b0;
         div_act_q <= scg_pkg::SCG_DIV_RST;
         div_cnt_q <= '0;
         cpu_core_clock_q <= 1'b0;
         pclk_q <= 1'b0;
         cko_q <= 1'b0;
      end
      else if (ce)
      begin
         osc_q <= osc_sel;
         if (div_q == '0)
         begin
            div_act_q <= '0;
            div_cnt_q <= '0;
            cpu_core_clock_q <= run_q && osc_sel;
         end
         else if (osc_rise && run_q)
         begin
            if (div_end)
            begin
               div_cnt_q <= '0;
               // ratio switches as a high phase ends, or at the first edge after ratio 0
               if (cpu_core_clock_q)
                  div_act_q <= div_q;
               cpu_core_clock_q <= !cpu_core_clock_q;
            end
            else
               div_cnt_q <= div_cnt_q + 1'b1;
            if (div_act_q == '0)
               div_act_q <= div_q;
         end
         if (cpu_core_clock_q == 1'b0 && cpu_core_clock_d_next)
         begin
            pclk_q <= !pclk_q;
            cko_q <= !cko_q;
         end
      end
   end

   assign cpu_core_clock_d_next = (div_q == '0) ? (run_q && osc_sel) :
      ((osc_rise && run_q && div_end) ? !cpu_core_clock_q : cpu_core_clock_q);

   // clock out only when the crystal is free of cpu and rtc use
   wire logic clk_out_ok = !xtal_src && !rtc_on_xtal;
   wire logic clk_out_drv = clk_out_ok && clk_out_en_q;

   assign rdata = rdata_q;
   assign rc_trim = trim_q;
   assign low_power_clock_select = lp_q;
   assign cpu_core_clock = cpu_core_clock_q;
   assign periph_clock = pclk_q;
   assign cpu_clock_run = run_q;
   // external mode: pin is a port or the clock output
   assign crystal_output_pin.clk_out_o = clk_out_drv ? cko_q :
      port_out;
   assign crystal_output_pin.clk_out_oe_n = clk_out_drv ? 1'b0 :
      (xtal_src ? 1'b1 : port_oe_n);

endmodule

// ===== scg_props.sv
/* assertion checker for the clock block, bound to its ports.
   assumes one clk_sys domain; por disables, rst is observed. */
`timescale 1ns/1ps
module scg_props
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic por,
   input wire logic ce,
   input wire scg_pkg::scg_src_e src_cfg,
   input wire scg_pkg::scg_bus_req_s bus,
   input wire logic [7:0] rdata,
   input wire logic [5:0] rc_trim,
   input wire logic low_power_clock_select,
   input wire logic cpu_core_clock,
   input wire logic cpu_clock_run,
   input wire scg_pkg::scg_pin_s crystal_output_pin
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (por);
   sequence s_wr_trim;
      bus.wr && bus.addr == scg_pkg::SCG_OFS_TRIM && ce && !rst;
   endsequence
   sequence s_rd_trim;
      bus.rd && bus.addr == scg_pkg::SCG_OFS_TRIM && ce && !rst;
   endsequence
   a_trim_por: assert property (
      $fell(por) |-> rc_trim == scg_pkg::SCG_TRIM_RST)
      else $error("trim not at factory value");
   a_trim_keep: assert property (
      rst && !por |=> $stable(rc_trim))
      else $error("plain reset changed trim");
   a_lp_clear: assert property (
      rst |=> !low_power_clock_select)
      else $error("low-power select survived reset");
   a_run_clear: assert property (
      rst |=> !cpu_clock_run)
      else $error("wake-up done during reset");
   a_cpu_gated: assert property (
      !cpu_clock_run |-> !cpu_core_clock)
      else $error("cpu clock ran before wake-up");
   a_pin_xtal: assert property (
      $stable(src_cfg) && src_cfg <= scg_pkg::SCG_SRC_XTAL_HIGH
      |-> crystal_output_pin.clk_out_oe_n)
      else $error("pin driven in crystal mode");
   a_trim_read: assert property (
      s_rd_trim |=> rdata[5:0] == $past(rc_trim))
      else $error("trim read data wrong");
   a_trim_write: assert property (
      s_wr_trim |=> rc_trim == $past(bus.wdata[5:0]))
      else $error("trim write lost");
endmodule
bind scg_top scg_props i_props (.clk_sys, .rst, .por, .ce, .src_cfg,
   .bus, .rdata, .rc_trim, .low_power_clock_select, .cpu_core_clock,
   .cpu_clock_run, .crystal_output_pin);

// ===== scg_osc_model.sv
/* oscillator and external clock source model.
   assumes sources are levels on clk_sys; HALF sets the rate. */
`timescale 1ns/1ps
module scg_osc_model
#(
   parameter int HALF = 3
)
(
   input wire logic clk_sys,
   output logic xtal_osc,
   output logic rc_osc,
   output logic wdog_osc,
   output logic crystal_input_pin
);
   int cnt = 0;
   logic lvl = 1'b0;
   always @(posedge clk_sys)
   begin
      cnt <= cnt == HALF - 1 ? 0 : cnt + 1;
      lvl <= lvl ^ (cnt == HALF - 1);
   end
   // sixth of clk_sys keeps the cpu clock under its limit
   assign xtal_osc = lvl; // any crystal range
   assign rc_osc = lvl;
   assign wdog_osc = lvl;
   assign crystal_input_pin = lvl; // well under the limit
endmodule

// ===== tb_system_clock_generation.sv
/* self-checking bench: resets, wake-up, trim, divider, clock out.
   assumes the oscillator model and the bound checker. */
`timescale 1ns/1ps
module tb_system_clock_generation;
   localparam int H = 3;
   localparam logic [3:0] TR = scg_pkg::SCG_OFS_TRIM;
   logic clk_sys = 0, rst = 1, por = 1, ce = 1, rtc_on_xtal = 0;
   logic port_out = 0, port_oe_n = 1, xtal_osc, rc_osc, wdog_osc;
   logic crystal_input_pin, run, cc, pc, lp;
   logic [7:0] q, rdata;
   logic [5:0] trim;
   logic [2:0] ck;
   logic [7:0] dv[4] = '{8'h00, 8'h01, 8'h03, 8'hff};
   scg_pkg::scg_src_e src_cfg = scg_pkg::SCG_SRC_RC;
   scg_pkg::scg_bus_req_s bus = '0;
   scg_pkg::scg_pin_s pin;
   int fail_count = 0, tests_run = 0, seed = 25801, v, n, e;
   always #50 clk_sys = ~clk_sys;
   assign ck = {pin.clk_out_o, pc, cc};
   scg_osc_model #(.HALF(H)) i_osc (.clk_sys, .xtal_osc, .rc_osc,
      .wdog_osc, .crystal_input_pin);
   // short wake counts keep the run brief
   scg_top #(.XTAL_WAKE(8), .OTHER_WAKE(4), .FIX_WAKE(4)) i_dut (.clk_sys,
      .rst, .por, .ce, .src_cfg, .rtc_on_xtal, .xtal_osc, .rc_osc,
      .wdog_osc, .crystal_input_pin, .port_out, .port_oe_n, .bus, .rdata,
      .rc_trim(trim), .low_power_clock_select(lp), .cpu_core_clock(cc),
      .periph_clock(pc), .cpu_clock_run(run), .crystal_output_pin(pin));
   function automatic int rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [3:0] a,
      input logic [7:0] d, output logic [7:0] r);
      @(posedge clk_sys);
      bus <= '{a, d, w, !w};
      @(posedge clk_sys);
      bus <= '0;
      #1 r = rdata;
   endtask
   task automatic rst_seq(input logic p);
      rst <= 1;
      por <= p;
      repeat (2) @(posedge clk_sys);
      rst <= 0;
      por <= 0;
   endtask
   task automatic per(input int i, output int p);
      time t;
      @(posedge ck[i]);
      t = $time;
      @(posedge ck[i]);
      p = ($time - t) / 100;
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      #(60000 * 100);
      fail_count++;
      report_and_stop;
   end
   initial
   begin
      rst_seq(1);
      acc(0, TR, 8'h00, q);
      chk(q[5:0], scg_pkg::SCG_TRIM_RST);
      port_oe_n <= 0;
      for (int s = 0; s < 6; s++)
      begin
         src_cfg <= scg_pkg::scg_src_e'(s);
         rst_seq(0);
         n = 0;
         while (run !== 1'b1 && n < 500)
         begin
            @(posedge clk_sys);
            #1 n++;
         end
         e = (s < 3 ? 8 : 4) * 2 * H;
         chk(n >= e - 2 * H && n <= e + 2 * H + 8, 1);
         chk(pin.clk_out_oe_n, s < 3);
      end
      $display("wake-up test done");
      v = rnd();
      acc(1, TR, {2'b00, v[5:0]}, q);
      acc(1, scg_pkg::SCG_OFS_AUX1, 8'h80, q);
      chk(lp, 1);
      acc(0, TR, 8'h00, q);
      chk(q, {2'b00, v[5:0]});
      acc(0, 4'hf, 8'h00, q);
      chk(q, 0);
      rst_seq(0);
      #1 chk(trim, v[5:0]);
      chk(lp, 0);
      $display("trim test done");
      acc(1, TR, {2'b01, v[5:0]}, q);
      foreach (dv[k])
      begin
         acc(1, scg_pkg::SCG_OFS_DIV, dv[k], q);
         e = dv[k] == 0 ? 2 * H : 4 * H * dv[k];
         per(0, n);
         per(0, n);
         chk(n, e);
         per(1, n);
         chk(n, 2 * e);
         per(2, n);
         chk(n, 2 * e);
         chk(pin.clk_out_oe_n, 0);
      end
      $display("divider test done");
      rtc_on_xtal <= 1;
      port_out <= v[7];
      repeat (2) @(posedge clk_sys);
      #1 chk(pin, {port_out, port_oe_n});
      rtc_on_xtal <= 0;
      acc(1, TR, 8'h00, q);
      repeat (2) @(posedge clk_sys);
      #1 chk(pin, {port_out, port_oe_n});
      @(posedge clk_sys);
      ce <= 0;
      @(posedge clk_sys);
      #1 q = {pc, cc, trim};
      repeat (20) @(posedge clk_sys);
      #1 chk({pc, cc, trim}, q);
      @(posedge clk_sys);
      ce <= 1;
      $display("clock out test done");
      report_and_stop;
   end
endmodule
